// file: hdl/pin_change_pkg.sv
package pin_change_pkg;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [5:0] ADDR_A_RISE = 6'h00;
  localparam logic [5:0] ADDR_A_FALL = 6'h04;
  localparam logic [5:0] ADDR_A_FLAGS = 6'h08;
  localparam logic [5:0] ADDR_B_RISE = 6'h0C;
  localparam logic [5:0] ADDR_B_FALL = 6'h10;
  localparam logic [5:0] ADDR_B_FLAGS = 6'h14;
  localparam logic [5:0] ADDR_CONTROL = 6'h18;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h1C;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h20;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam logic [7:0] PORT_A_IMPL = 8'h3F;
  localparam logic [7:0] PORT_B_IMPL = 8'hF0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_AGGREGATE_BIT = 1;
  localparam int IRQ_A_BIT = 0;
  localparam int IRQ_B_BIT = 1;
  localparam logic [1:0] IRQ_IMPL = 2'h3;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ****************************************
  // bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one held write request: address, data and strobes travel together
  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } write_req_type;

  // one read answer
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } read_ans_type;

endpackage : pin_change_pkg

// file: hdl/pin_change_edge_detector.sv
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] port A pins 0-5 see rising edges only while their rise enable is set.
// [R2] port A pins 0-5 see falling edges only while their fall enable is set.
// [R3] an enabled rising edge on a port A pin sets its change flag.
// [R4] an enabled falling edge on a port A pin sets its change flag.
// [R5] any flag set by an enabled edge also sets the aggregate flag.
// [R6] flags set only by hardware; software reads them and clears by writing zero.
// [R7] each implemented flag bit is hardware-set plus software read/write.
// [R8] port B pins 4-7 detect enabled edges, setting their flag and aggregate.
// [R9] a direction whose enable bit is zero detects nothing.
// [R10] unimplemented enable and flag bits ignore writes and read zero.
// [R11] every implemented enable and flag bit resets to zero.
// [R12] detection runs regardless; interrupt raised only with change enable set.
// [R13] aggregate flag is the OR of all pin change flags.
// [R14] an edge during a clearing write leaves that flag set.
// [R15] software clears flags by masking out exactly the bits it saw set.
// [R16] pins are synchronised and compared with previous sample for one-cycle edges.
// [R17] both enables set make either polarity set the flag.
module pin_change_edge_detector
  import pin_change_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] port_a_pin,
  input wire logic [7:0] port_b_pin,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic aggregate_change_flag,
  output logic irq
);

  // ****************************************
  // helpers
  // ****************************************
  // software write into an enable byte; only lane 0 carries data
  function automatic logic [7:0] write_byte(input logic [7:0] old_val,
      input write_req_type req, input logic [7:0] impl);
    write_byte = req.strb[0] ? (req.data[7:0] & impl) : old_val;
  endfunction : write_byte

  // enabled edges of one port, either polarity
  function automatic logic [7:0] enabled_edges(input logic [7:0] now_val,
      input logic [7:0] prev_val, input logic [7:0] rise_en,
      input logic [7:0] fall_en, input logic [7:0] impl);
    enabled_edges = ((now_val & ~prev_val & rise_en) |
                     (~now_val & prev_val & fall_en)) & impl;
  endfunction : enabled_edges

  // hardware-set, software-clear byte: a set in the clearing cycle wins
  function automatic logic [7:0] sticky_byte(input logic [7:0] old_val,
      input logic clear_en, input logic [7:0] keep, input logic [7:0] set_val);
    sticky_byte = (clear_en ? (old_val & keep) : old_val) | set_val;
  endfunction : sticky_byte

  // ****************************************
  // pin synchronisers and edge detect
  // ****************************************
  logic [7:0] a_meta_reg;
  logic [7:0] a_sync_reg;
  logic [7:0] a_prev_reg;
  logic [7:0] b_meta_reg;
  logic [7:0] b_sync_reg;
  logic [7:0] b_prev_reg;

  // the first flop may go metastable; nothing but the second flop reads it
  // [R16] two-flop sync then compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_meta_reg <= BYTE_RESET;
      a_sync_reg <= BYTE_RESET;
      a_prev_reg <= BYTE_RESET;
      b_meta_reg <= BYTE_RESET;
      b_sync_reg <= BYTE_RESET;
      b_prev_reg <= BYTE_RESET;
    end else begin
      a_meta_reg <= port_a_pin;
      a_sync_reg <= a_meta_reg;
      a_prev_reg <= a_sync_reg;
      b_meta_reg <= port_b_pin;
      b_sync_reg <= b_meta_reg;
      b_prev_reg <= b_sync_reg;
    end
  end

  logic [7:0] a_rise_en_reg;
  logic [7:0] a_fall_en_reg;
  logic [7:0] a_flags_reg;
  logic [7:0] b_rise_en_reg;
  logic [7:0] b_fall_en_reg;
  logic [7:0] b_flags_reg;
  logic ctrl_enable_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;

  // [R1] [R2] [R9] [R17] per-direction gating
  wire logic [7:0] a_set = enabled_edges(a_sync_reg, a_prev_reg, a_rise_en_reg,
                                         a_fall_en_reg, PORT_A_IMPL);
  // [R8] port B upper nibble
  wire logic [7:0] b_set = enabled_edges(b_sync_reg, b_prev_reg, b_rise_en_reg,
                                         b_fall_en_reg, PORT_B_IMPL);

  // ****************************************
  // write channel
  // ****************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [5:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  // only the low six address bits are decoded: the map repeats every 64 bytes
  // a held pair waits until the previous answer is taken, so one write is in flight
  wire logic aw_take = s_axi_awvalid && !aw_held_reg;
  wire logic w_take = s_axi_wvalid && !w_held_reg;
  // address and data may arrive in either order; commit once both are held
  wire logic do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire write_req_type wreq = '{addr: awaddr_reg, data: wdata_reg, strb: wstrb_reg};

  wire logic wr_a_rise = do_write && (wreq.addr == ADDR_A_RISE);
  wire logic wr_a_fall = do_write && (wreq.addr == ADDR_A_FALL);
  wire logic wr_a_flags = do_write && (wreq.addr == ADDR_A_FLAGS);
  wire logic wr_b_rise = do_write && (wreq.addr == ADDR_B_RISE);
  wire logic wr_b_fall = do_write && (wreq.addr == ADDR_B_FALL);
  wire logic wr_b_flags = do_write && (wreq.addr == ADDR_B_FLAGS);
  wire logic wr_ctrl = do_write && (wreq.addr == ADDR_CONTROL);
  wire logic wr_mask = do_write && (wreq.addr == ADDR_IRQ_MASK);
  wire logic wr_status = do_write && (wreq.addr == ADDR_IRQ_STATUS);
  wire logic wr_hit = wr_a_rise || wr_a_fall || wr_a_flags || wr_b_rise ||
                      wr_b_fall || wr_b_flags || wr_ctrl || wr_mask || wr_status;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 6'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr[5:0];
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // enable, flag and interrupt registers
  // ****************************************
  logic ar_take;
  logic rd_status;

  // [R6] [R7] [R14] software may only clear; a same-cycle edge wins
  wire logic [7:0] a_flags_next =
    sticky_byte(a_flags_reg, wr_a_flags && wreq.strb[0], wreq.data[7:0], a_set);
  wire logic [7:0] b_flags_next =
    sticky_byte(b_flags_reg, wr_b_flags && wreq.strb[0], wreq.data[7:0], b_set);

  // status events are flags being raised; read clears, set wins
  wire logic [1:0] irq_events = {(|b_set), (|a_set)};
  wire logic [1:0] irq_status_next =
    (rd_status ? IRQ_RESET : irq_status_reg) | irq_events;

  always_ff @(posedge aclk) begin
    // [R11] everything clears on any reset
    if (!aresetn) begin
      a_rise_en_reg <= BYTE_RESET;
      a_fall_en_reg <= BYTE_RESET;
      a_flags_reg <= BYTE_RESET;
      b_rise_en_reg <= BYTE_RESET;
      b_fall_en_reg <= BYTE_RESET;
      b_flags_reg <= BYTE_RESET;
      ctrl_enable_reg <= 1'b0;
      irq_status_reg <= IRQ_RESET;
      irq_mask_reg <= IRQ_RESET;
    end else begin
      // [R10] unimplemented bits masked on write
      if (wr_a_rise) a_rise_en_reg <= write_byte(a_rise_en_reg, wreq, PORT_A_IMPL);
      if (wr_a_fall) a_fall_en_reg <= write_byte(a_fall_en_reg, wreq, PORT_A_IMPL);
      if (wr_b_rise) b_rise_en_reg <= write_byte(b_rise_en_reg, wreq, PORT_B_IMPL);
      if (wr_b_fall) b_fall_en_reg <= write_byte(b_fall_en_reg, wreq, PORT_B_IMPL);
      // [R3] [R4] [R8] flags take enabled edges
      a_flags_reg <= a_flags_next & PORT_A_IMPL;
      b_flags_reg <= b_flags_next & PORT_B_IMPL;
      if (wr_ctrl && wreq.strb[0]) ctrl_enable_reg <= wreq.data[CTRL_ENABLE_BIT];
      if (wr_mask && wreq.strb[0]) irq_mask_reg <= wreq.data[1:0] & IRQ_IMPL;
      irq_status_reg <= irq_status_next;
    end
  end

  // taken straight from the flag registers, so it drops with the clearing write
  // [R5] [R13] aggregate is the OR of every pin flag
  wire logic aggregate = (|a_flags_reg) || (|b_flags_reg);
  assign aggregate_change_flag = aggregate;

  // [R12] detection never stops; only the request is gated
  wire logic irq_level = ctrl_enable_reg && (|(irq_status_reg & irq_mask_reg));

  // registered so the pin cannot glitch while status, mask and enable settle
  logic irq_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_level;
    end
  end
  assign irq = irq_reg;

  // ****************************************
  // read channel
  // ****************************************
  logic rvalid_reg;
  read_ans_type rans_reg;

  // one answer slot: a new address waits until the held answer is taken,
  // so the data of a clearing status read can never be overwritten
  assign ar_take = s_axi_arvalid && !rvalid_reg;
  wire logic [5:0] raddr = s_axi_araddr[5:0];
  assign rd_status = ar_take && (raddr == ADDR_IRQ_STATUS);

  // [R10] unimplemented bits already held at zero
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    unique case (raddr)
      ADDR_A_RISE: rd_mux[7:0] = a_rise_en_reg;
      ADDR_A_FALL: rd_mux[7:0] = a_fall_en_reg;
      ADDR_A_FLAGS: rd_mux[7:0] = a_flags_reg;
      ADDR_B_RISE: rd_mux[7:0] = b_rise_en_reg;
      ADDR_B_FALL: rd_mux[7:0] = b_fall_en_reg;
      ADDR_B_FLAGS: rd_mux[7:0] = b_flags_reg;
      ADDR_CONTROL: begin
        rd_mux[CTRL_ENABLE_BIT] = ctrl_enable_reg;
        rd_mux[CTRL_AGGREGATE_BIT] = aggregate;
      end
      ADDR_IRQ_STATUS: rd_mux[1:0] = irq_status_reg;
      ADDR_IRQ_MASK: rd_mux[1:0] = irq_mask_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rans_reg.data;
  assign s_axi_rresp = rans_reg.resp;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rans_reg <= '{data: 32'h00000000, resp: RESP_OKAY};
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rans_reg <= '{data: rd_mux, resp: rd_hit ? RESP_OKAY : RESP_SLVERR};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : pin_change_edge_detector

// file: dv/pin_change_checker.sv
`timescale 1ns/1ps
module pin_change_checker
  import pin_change_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] port_a_pin,
  input wire logic [7:0] port_b_pin,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic aggregate_change_flag,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_clear: assert property ($rose(aresetn) |-> !aggregate_change_flag && !irq)
    else $error("flag or irq high after reset");
  a_flag_cause: assert property ($rose(aggregate_change_flag) |->
    |((($past(port_a_pin, 3) ^ $past(port_a_pin, 4)) & PORT_A_IMPL) |
    (($past(port_b_pin, 3) ^ $past(port_b_pin, 4)) & PORT_B_IMPL)))
    else $error("flag set without a pin edge");
  a_agg_sticky: assert property ($fell(aggregate_change_flag) |-> $rose(s_axi_bvalid))
    else $error("flag cleared without a write");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_aw_refuse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address taken twice");
  a_bvalid_commit: assert property ($rose(s_axi_bvalid) |->
    $past(!s_axi_awready && !s_axi_wready))
    else $error("response without held request");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule : pin_change_checker

bind pin_change_edge_detector pin_change_checker chk_u (.aclk, .aresetn, .port_a_pin,
  .port_b_pin, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .aggregate_change_flag, .irq);

// file: dv/pin_source_model.sv
`timescale 1ns/1ps
module pin_source_model (
  input wire logic aclk,
  input wire logic [7:0] a_level,
  input wire logic [7:0] b_level,
  output logic [7:0] port_a_pin = 8'h00,
  output logic [7:0] port_b_pin = 8'h00
);
  // pins move just after an edge, so every change lasts whole cycles
  always @(posedge aclk) begin
    port_a_pin <= a_level;
    port_b_pin <= b_level;
  end
endmodule : pin_source_model

// file: dv/pin_change_edge_detector_tb.sv
`timescale 1ns/1ps
module pin_change_edge_detector_tb;
  import pin_change_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  wire awready, wready, bvalid, arready, rvalid, agg, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pa, pb;
  logic [7:0] a_lvl = 8'h00, b_lvl = 8'h00, ea, eb, re, fe;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [31:0] seed = 32'h0001338B;
  int num_errors = 0, n_tests = 0, cyc = 0;

  initial forever #20 aclk = ~aclk;

  pin_source_model pins_u (.aclk(aclk), .a_level(a_lvl), .b_level(b_lvl),
    .port_a_pin(pa), .port_b_pin(pb));
  pin_change_edge_detector dut_u (.aclk(aclk), .aresetn(aresetn), .port_a_pin(pa),
    .port_b_pin(pb), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .aggregate_change_flag(agg), .irq(irq));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // each task opens on a fresh edge so no signal is assigned twice in one step
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge aclk);
    bq.push_back(a <= ADDR_IRQ_MASK ? RESP_OKAY : RESP_SLVERR);
    awaddr <= {26'h0, a};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge aclk);
    rq.push_back(a <= ADDR_IRQ_MASK ? {RESP_OKAY, 24'h0, e} : {RESP_SLVERR, 32'h0});
    araddr <= {26'h0, a};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
  endtask : rd

  // ****************************************
  // result watcher and timeout
  // ****************************************
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i <= 9; i++) rd(6'(4 * i), 8'h00);
    wr(6'h24, 32'hFF);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      wr(6'(4 * i), seed);
      rd(6'(4 * i), seed[7:0] & (i == 2 ? 8'h00 : i < 2 ? PORT_A_IMPL : PORT_B_IMPL));
    end
    wr(ADDR_IRQ_MASK, 32'h3);
    // mode 0 rise only, 1 fall only, 2 both, 3 both with interrupt off
    for (int m = 0; m < 4; m++) begin
      re = (m != 1) ? 8'hFF : 8'h00;
      fe = (m != 0) ? 8'hFF : 8'h00;
      wr(ADDR_A_RISE, {24'h0, re});
      wr(ADDR_A_FALL, {24'h0, fe});
      wr(ADDR_B_RISE, {24'h0, re});
      wr(ADDR_B_FALL, {24'h0, fe});
      wr(ADDR_CONTROL, 32'(m < 3));
      seed = lfsr(seed);
      ea = ((re & seed[7:0] & ~a_lvl) | (fe & ~seed[7:0] & a_lvl)) & PORT_A_IMPL;
      eb = ((re & seed[15:8] & ~b_lvl) | (fe & ~seed[15:8] & b_lvl)) & PORT_B_IMPL;
      a_lvl <= seed[7:0];
      b_lvl <= seed[15:8];
      repeat (8) @(posedge aclk);
      chk(agg, |{ea, eb});
      chk(irq, m < 3 && |{ea, eb});
      rd(ADDR_A_FLAGS, ea);
      rd(ADDR_B_FLAGS, eb);
      rd(ADDR_CONTROL, {6'h0, |{ea, eb}, m < 3});
      rd(ADDR_IRQ_STATUS, {6'h0, |eb, |ea});
      // clear only the bits seen set
      wr(ADDR_A_FLAGS, {24'h0, ~ea});
      wr(ADDR_B_FLAGS, {24'h0, ~eb});
      rd(ADDR_A_FLAGS, 8'h00);
      rd(ADDR_B_FLAGS, 8'h00);
    end
    // pin 0 toggles so its edge sets the flag on the edge the clearing write commits
    @(posedge aclk);
    a_lvl <= a_lvl ^ 8'h01;
    @(posedge aclk);
    wr(ADDR_A_FLAGS, 32'h0);
    rd(ADDR_A_FLAGS, 8'h01);
    // reset again with enables and a flag set; four edges keep the checker disabled
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ADDR_A_FLAGS, 8'h00);
    rd(ADDR_B_FALL, 8'h00);
    // let the watcher take the last answer before the verdict
    repeat (2) @(posedge aclk);
    chk(34'(rq.size() + bq.size()), 34'h0);
    stop_test();
  end
endmodule : pin_change_edge_detector_tb
